// >>> rtl/dmactl_regs.vh
// Register indexes, byte addresses, field positions and timing counts.
`ifndef DMACTL_REGS_VH
`define DMACTL_REGS_VH

// Printed register indexes; each register's byte address is four times this.
`define DMACTL_IDX_MODE0     20'hFFFBA
`define DMACTL_IDX_MODE1     20'hFFFBB
`define DMACTL_IDX_OPER0     20'hFFFBC
`define DMACTL_IDX_OPER1     20'hFFFBD
`define DMACTL_IDX_PERIPH0   20'hFFFB0
`define DMACTL_IDX_PERIPH1   20'hFFFB1
`define DMACTL_IDX_RAMPTR0   20'hFFFC0
`define DMACTL_IDX_RAMPTR1   20'hFFFC1
`define DMACTL_IDX_COUNT0    20'hFFFC2
`define DMACTL_IDX_COUNT1    20'hFFFC3

// Width of the decoded byte address (index plus two word bits).
`define DMACTL_AW            22

// Mode register fields.
`define DMACTL_MODE_TRIG     7
`define DMACTL_MODE_DIR      6
`define DMACTL_MODE_SIZE     5
`define DMACTL_MODE_HOLD     4
`define DMACTL_MODE_SRC_HI   3
`define DMACTL_MODE_SRC_LO   0

// Operation register fields.
`define DMACTL_OPER_EN       7
`define DMACTL_OPER_BUSY     0

// Reset values.
`define DMACTL_RST_MODE      8'h00
`define DMACTL_RST_OPER      8'h00
`define DMACTL_RST_PERIPH    8'h00
`define DMACTL_RST_RAMPTR    16'h0000
`define DMACTL_RST_COUNT     10'h000

// Start source codes.
`define DMACTL_SRC_NONE      4'h0
`define DMACTL_SRC_LAST      4'hC

// Cycles from setting the hold bit until the hold takes effect.
`define DMACTL_HOLD_DELAY    2

// Engine states.
`define DMACTL_ST_IDLE       2'h0
`define DMACTL_ST_READ       2'h1
`define DMACTL_ST_WRITE      2'h2

`endif

// >>> rtl/dmactl_top.v
// Two-channel DMA control and mode logic with an AHB-Lite register slave.
`timescale 1ns/10ps
// Notes on behaviour
// - Mode and operation registers take bit/byte writes.
// - Trigger bit launches one transfer, reads zero.
// - Direction bit picks peripheral-to-RAM or RAM-to-peripheral.
// - Size bit picks byte or halfword items.
// - Hold bit set keeps start requests pending.
// - Clearing hold releases the pending request.
// - Hold takes effect two clocks after setting.
// - Software trigger works for any source.
// - Source zero disables hardware starts.
// - Codes 2-5 pick timer 0,1,4,5 events.
// - Codes 6-11 pick the serial unit events.
// - Code 12 picks conversion end; others forbidden.
// - Enable low stops the channel entirely.
// - Enabled busy channel waits for its trigger.
// - Busy flag clears when the sequence finishes.
// - Writing busy flag zero aborts the sequence.
// - Count reaching zero raises completion, stops.
// - Abort raises nothing, keeps count and pointer.
// - Count minus one, RAM pointer plus 1/2.
// - Same source: channel 0 served before 1.
`include "dmactl_regs.vh"

module dmactl_top (
	// Clock and reset.
	input  wire        clk,
	input  wire        rst,
	// AHB-Lite slave.
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	// Peripheral start events, one-cycle pulses.
	input  wire        timer0Event,
	input  wire        timer1Event,
	input  wire        timer4Event,
	input  wire        timer5Event,
	input  wire        serial0TxEvent,
	input  wire        clockedSerial00Event,
	input  wire        serial0RxEvent,
	input  wire        serial1TxEvent,
	input  wire        clockedSerial10Event,
	input  wire        twowire10Event,
	input  wire        serial1RxEvent,
	input  wire        serial3TxEvent,
	input  wire        serial3RxEvent,
	input  wire        conversionDoneEvent,
	// Transfer port towards the peripheral register and RAM bus.
	output reg         xferRead,
	output reg         xferWrite,
	output reg         xferDir,
	output reg         xferWide,
	output reg         xferChan,
	output reg  [15:0] xferRamAddr,
	output reg  [7:0]  xferPeriphAddr,
	output reg         cpuHold,
	// Completion requests, one-cycle pulses.
	output reg         completionIrq0,
	output reg         completionIrq1
);

	// Mode register per channel; the trigger bit is never stored.
	reg  [7:0]  modeReg_ff [0:1];
	// Enable and busy flags per channel.
	reg  [1:0]  enable_ff;
	reg  [1:0]  inProgress_ff;
	// Pointers and remaining counts per channel.
	reg  [7:0]  periphPtr_ff [0:1];
	reg  [15:0] ramPtr_ff [0:1];
	reg  [9:0]  count_ff [0:1];
	// Start request waiting for service.
	reg  [1:0]  pending_ff;
	// Hold bit delayed by two clocks.
	reg  [1:0]  holdDly1_ff;
	reg  [1:0]  holdDly2_ff;
	// Engine state and the channel it is serving.
	reg  [1:0]  state_ff;
	reg         engChan_ff;
	// Captured write address phase.
	reg         wrPend_ff;
	reg  [`DMACTL_AW-1:0] wrAddr_ff;

	// Combinational helpers.
	reg  [15:0] evtVec;
	reg  [1:0]  hwTrig;
	reg  [1:0]  ready;
	reg  [1:0]  effHold;
	reg  [31:0] nxt_hrdata;
	wire        addrPhase;
	wire [`DMACTL_AW-1:0] byteAddr;
	wire [7:0]  wByte;
	// One loop index per process, so that no variable has two writers.
	integer     iComb;  // Index of the combinational per-channel loop.
	integer     iHold;  // Index of the hold delay loop.
	integer     iReg;   // Index of the channel register loops.

	// An address phase counts only when the slave is selected with a
	// NONSEQ or SEQ transfer while the bus is ready.
	assign addrPhase = hsel & htrans[1] & hready;
	assign byteAddr  = haddr[`DMACTL_AW-1:0];
	assign wByte     = hwdata[7:0];

	// Events arranged by source code; combined sources share one code.
	// Codes 0, 1 and 13 to 15 have no line, so no hardware event ever starts a channel on them.
	always @* begin
		evtVec      = 16'h0000;
		evtVec[2]   = timer0Event;
		evtVec[3]   = timer1Event;
		evtVec[4]   = timer4Event;
		evtVec[5]   = timer5Event;
		evtVec[6]   = serial0TxEvent | clockedSerial00Event;
		evtVec[7]   = serial0RxEvent;
		evtVec[8]   = serial1TxEvent | clockedSerial10Event | twowire10Event;
		evtVec[9]   = serial1RxEvent;
		evtVec[10]  = serial3TxEvent;
		evtVec[11]  = serial3RxEvent;
		evtVec[12]  = conversionDoneEvent;
	end

	// Per channel: selected hardware event, effective hold, service request.
	// The hold and the request are plain decodes of flip-flops, so the engine sees a
	// stable picture for the whole cycle; the event comes straight from the inputs.
	always @* begin
		for (iComb = 0; iComb < 2; iComb = iComb + 1) begin
			// Code zero and the unassigned codes have no event wired.
			hwTrig[iComb]  = evtVec[modeReg_ff[iComb][3:0]];
			// A newly set hold only bites once both delay stages agree;
			// clearing it releases at once.
			effHold[iComb] = modeReg_ff[iComb][`DMACTL_MODE_HOLD] &
				holdDly2_ff[iComb];
			// A request is served only on an enabled, busy, unheld channel.
			ready[iComb]   = pending_ff[iComb] & ~effHold[iComb] &
				enable_ff[iComb] & inProgress_ff[iComb];
		end
	end

	// Read multiplexer, sampled in the address phase for a zero-wait reply.
	// Unused upper bits of every register read as zero.
	always @* begin
		nxt_hrdata = 32'h00000000;
		case (byteAddr)
			{`DMACTL_IDX_MODE0, 2'b00}:
				nxt_hrdata[7:0] = {1'b0, modeReg_ff[0][6:0]};
			{`DMACTL_IDX_MODE1, 2'b00}:
				nxt_hrdata[7:0] = {1'b0, modeReg_ff[1][6:0]};
			{`DMACTL_IDX_OPER0, 2'b00}:
				nxt_hrdata[7:0] = {enable_ff[0], 6'h00, inProgress_ff[0]};
			{`DMACTL_IDX_OPER1, 2'b00}:
				nxt_hrdata[7:0] = {enable_ff[1], 6'h00, inProgress_ff[1]};
			{`DMACTL_IDX_PERIPH0, 2'b00}: nxt_hrdata[7:0]  = periphPtr_ff[0];
			{`DMACTL_IDX_PERIPH1, 2'b00}: nxt_hrdata[7:0]  = periphPtr_ff[1];
			{`DMACTL_IDX_RAMPTR0, 2'b00}: nxt_hrdata[15:0] = ramPtr_ff[0];
			{`DMACTL_IDX_RAMPTR1, 2'b00}: nxt_hrdata[15:0] = ramPtr_ff[1];
			{`DMACTL_IDX_COUNT0, 2'b00}:  nxt_hrdata[9:0]  = count_ff[0];
			{`DMACTL_IDX_COUNT1, 2'b00}:  nxt_hrdata[9:0]  = count_ff[1];
			// Unmapped addresses read as zero with an OKAY response.
			default: nxt_hrdata = 32'h00000000;
		endcase
	end

	// Bus slave: address capture and read data; ready from the first clock after reset, always OKAY.
	// Read data is latched in the address phase and stands through the
	// data phase; the price is that a read never sees a write in flight.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			hrdata    <= 32'h00000000;
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
			wrPend_ff <= 1'b0;
			wrAddr_ff <= {`DMACTL_AW{1'b0}};
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			wrPend_ff <= addrPhase & hwrite;
			if (addrPhase) begin
				wrAddr_ff <= byteAddr;
				if (!hwrite) begin
					hrdata <= nxt_hrdata;
				end
			end
		end
	end

	// Hold delay line; a cleared hold bit empties it immediately.
	// The two stages give the grace in which a request that arrives
	// just after the hold is set is still served.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			holdDly1_ff <= 2'b00;
			holdDly2_ff <= 2'b00;
		end else begin
			for (iHold = 0; iHold < 2; iHold = iHold + 1) begin
				holdDly1_ff[iHold] <=
					modeReg_ff[iHold][`DMACTL_MODE_HOLD];
				holdDly2_ff[iHold] <= holdDly1_ff[iHold] &
					modeReg_ff[iHold][`DMACTL_MODE_HOLD];
			end
		end
	end

	// Channel registers, pending requests and the transfer engine.
	// Everything a channel owns but its hold delay line lives in this one process, so every
	// register has exactly one writer.
	// A word write in the data phase stands for one 8-bit write (16 bits to a RAM pointer, 10 to a count); a
	// single-bit update by software is a read-modify-write of that byte.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			// Both channels leave reset disabled, idle and cleared.
			for (iReg = 0; iReg < 2; iReg = iReg + 1) begin
				modeReg_ff[iReg]   <= `DMACTL_RST_MODE;
				periphPtr_ff[iReg] <= `DMACTL_RST_PERIPH;
				ramPtr_ff[iReg]    <= `DMACTL_RST_RAMPTR;
				count_ff[iReg]     <= `DMACTL_RST_COUNT;
			end
			enable_ff      <= 2'b00;
			inProgress_ff  <= 2'b00;
			pending_ff     <= 2'b00;
			state_ff       <= `DMACTL_ST_IDLE;
			engChan_ff     <= 1'b0;
			xferRead       <= 1'b0;
			xferWrite      <= 1'b0;
			xferDir        <= 1'b0;
			xferWide       <= 1'b0;
			xferChan       <= 1'b0;
			xferRamAddr    <= 16'h0000;
			xferPeriphAddr <= 8'h00;
			cpuHold        <= 1'b0;
			completionIrq0 <= 1'b0;
			completionIrq1 <= 1'b0;
		end else begin
			// Pulse outputs fall back to zero unless set again below.
			completionIrq0 <= 1'b0;
			completionIrq1 <= 1'b0;
			xferRead       <= 1'b0;
			xferWrite      <= 1'b0;
			cpuHold        <= 1'b0;

			// Requests: only an enabled, busy channel records one.
			// A request that meets a disabled or finished channel is
			// dropped, not queued for later.
			for (iReg = 0; iReg < 2; iReg = iReg + 1) begin
				if (!enable_ff[iReg] || !inProgress_ff[iReg]) begin
					// Disabled or idle: forget any stale request.
					pending_ff[iReg] <= 1'b0;
				end else if (hwTrig[iReg]) begin
					// The selected source fired.
					pending_ff[iReg] <= 1'b1;
				end
			end

			// Engine: three clocks per item, channel 0 wins ties.
			case (state_ff)
				`DMACTL_ST_IDLE: begin
					// Channel 0 is looked at first, so it wins a shared trigger.
					if (ready[0] || ready[1]) begin
						engChan_ff <= ~ready[0];
						xferChan   <= ~ready[0];
						state_ff   <= `DMACTL_ST_READ;
						cpuHold    <= 1'b1;
						xferRead   <= 1'b1;
						xferDir    <= modeReg_ff[~ready[0]]
							[`DMACTL_MODE_DIR];
						xferWide   <= modeReg_ff[~ready[0]]
							[`DMACTL_MODE_SIZE];
						// Halfword items use even addresses only.
						xferRamAddr <= ramPtr_ff[~ready[0]] &
							{15'h7FFF,
							~modeReg_ff[~ready[0]][`DMACTL_MODE_SIZE]};
						xferPeriphAddr <= periphPtr_ff[~ready[0]] &
							{7'h7F,
							~modeReg_ff[~ready[0]][`DMACTL_MODE_SIZE]};
						// A trigger in this same cycle stays recorded.
						if (!hwTrig[~ready[0]]) begin
							pending_ff[~ready[0]] <= 1'b0;
						end
					end
				end
				`DMACTL_ST_READ: begin
					// Second cycle of the item: the source is read and the destination write is set up.
					state_ff  <= `DMACTL_ST_WRITE;
					cpuHold   <= 1'b1;
					xferWrite <= 1'b1;
				end
				`DMACTL_ST_WRITE: begin
					// Third cycle: counters move and completion is judged.
					state_ff <= `DMACTL_ST_IDLE;
					// An abort during the item leaves the counters alone.
					if (inProgress_ff[engChan_ff]) begin
						count_ff[engChan_ff] <=
							count_ff[engChan_ff] - 10'h001;
						ramPtr_ff[engChan_ff] <= ramPtr_ff[engChan_ff] +
							(modeReg_ff[engChan_ff][`DMACTL_MODE_SIZE] ?
							16'h0002 : 16'h0001);
						if (count_ff[engChan_ff] == 10'h001) begin
							// Last item: the flag drops and the request rises.
							inProgress_ff[engChan_ff] <= 1'b0;
							pending_ff[engChan_ff]    <= 1'b0;
							if (engChan_ff) begin
								completionIrq1 <= 1'b1;
							end else begin
								completionIrq0 <= 1'b1;
							end
						end
					end
				end
				// An unused code recovers to idle instead of hanging.
				default: state_ff <= `DMACTL_ST_IDLE;
			endcase

			// Software writes come last so a written 1 to the busy flag
			// wins over a completion in the same cycle.
			if (wrPend_ff) begin
				case (wrAddr_ff)
					{`DMACTL_IDX_MODE0, 2'b00}, {`DMACTL_IDX_MODE1, 2'b00}:
					begin
						// The trigger bit is never kept; it reads back as zero.
						modeReg_ff[wrAddr_ff[2]] <=
							{1'b0, wByte[6:0]};
						// A written 1 launches one item on any source.
						if (wByte[`DMACTL_MODE_TRIG] &&
							enable_ff[wrAddr_ff[2]] &&
							inProgress_ff[wrAddr_ff[2]]) begin
							pending_ff[wrAddr_ff[2]] <= 1'b1;
						end
					end
					{`DMACTL_IDX_OPER0, 2'b00}, {`DMACTL_IDX_OPER1, 2'b00}:
					begin
						// Index C maps to channel 0 and D to channel 1.
						inProgress_ff[wrAddr_ff[2]] <=
							wByte[`DMACTL_OPER_BUSY];
						// Writing zero to the busy flag is the abort.
						if (!wByte[`DMACTL_OPER_BUSY]) begin
							pending_ff[wrAddr_ff[2]] <= 1'b0;
						end
						// Enable only changes while the channel is idle.
						if (!inProgress_ff[wrAddr_ff[2]]) begin
							enable_ff[wrAddr_ff[2]] <=
								wByte[`DMACTL_OPER_EN];
						end
					end
					// Pointer and count writes are ignored while their channel is busy.
					{`DMACTL_IDX_PERIPH0, 2'b00}:
						if (!inProgress_ff[0]) periphPtr_ff[0] <= wByte;
					{`DMACTL_IDX_PERIPH1, 2'b00}:
						if (!inProgress_ff[1]) periphPtr_ff[1] <= wByte;
					{`DMACTL_IDX_RAMPTR0, 2'b00}:
						if (!inProgress_ff[0]) ramPtr_ff[0] <= hwdata[15:0];
					{`DMACTL_IDX_RAMPTR1, 2'b00}:
						if (!inProgress_ff[1]) ramPtr_ff[1] <= hwdata[15:0];
					{`DMACTL_IDX_COUNT0, 2'b00}:
						if (!inProgress_ff[0]) count_ff[0] <= hwdata[9:0];
					{`DMACTL_IDX_COUNT1, 2'b00}:
						if (!inProgress_ff[1]) count_ff[1] <= hwdata[9:0];
					default: ;
				endcase
			end
		end
	end

endmodule // dmactl_top

// >>> testbench/dmactl_evt_model.sv
// Model of the peripheral event sources that request transfers.
`timescale 1ns/10ps
module dmactl_evt_model (
	// Clock and reset.
	input  wire        clk,
	input  wire        rst,
	// Bench request: line index and fire strobe.
	input  wire [3:0]  lineIdx,
	input  wire        fire,
	// One-cycle event pulses, one bit per source line.
	output reg  [13:0] evt
);
	// One pulse per fire; indexes above 13 raise nothing at all.
	always @(posedge clk or posedge rst) begin
		if (rst)
			evt <= 14'h0000;
		else
			evt <= fire ? (14'h0001 << lineIdx) : 14'h0000;
	end
endmodule // dmactl_evt_model

// >>> testbench/dmactl_top_assertions.sv
// Checker of port-level timing rules of the DMA control block.
`timescale 1ns/10ps
module dmactl_chk (
	// Clock and reset.
	input wire        clk,
	input wire        rst,
	// Bus answer.
	input wire        hreadyout,
	input wire        hresp,
	// Transfer port and completion.
	input wire        xferRead,
	input wire        xferWrite,
	input wire        xferWide,
	input wire        xferChan,
	input wire [15:0] xferRamAddr,
	input wire [7:0]  xferPeriphAddr,
	input wire        cpuHold,
	input wire        completionIrq0,
	input wire        completionIrq1
);
	// All checks share one clock and are off while reset is high.
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property p_rd_wr; xferRead |=> xferWrite; endproperty
	a_rd_wr: assert property (p_rd_wr) else $error("write missing");
	property p_gap; xferRead |=> !xferRead [*2]; endproperty
	a_gap: assert property (p_gap) else $error("items too close");
	property p_hold; cpuHold == (xferRead || xferWrite); endproperty
	a_hold: assert property (p_hold) else $error("cpu hold wrong");
	property p_ready; !$past(rst) |-> hreadyout; endproperty
	a_ready: assert property (p_ready) else $error("bus not ready");
	property p_okay; !hresp; endproperty
	a_okay: assert property (p_okay) else $error("bus error response");
	property p_irq0; completionIrq0 |-> $past(xferWrite) && !xferChan; endproperty
	a_irq0: assert property (p_irq0) else $error("stray completion 0");
	property p_irq1; completionIrq1 |-> $past(xferWrite) && xferChan; endproperty
	a_irq1: assert property (p_irq1) else $error("stray completion 1");
	property p_excl; !(completionIrq0 && completionIrq1); endproperty
	a_excl: assert property (p_excl) else $error("two completions");
	property p_wide;
		xferRead && xferWide |-> !xferRamAddr[0] && !xferPeriphAddr[0];
	endproperty
	a_wide: assert property (p_wide) else $error("odd wide address");
	property p_info; xferWrite |-> $stable(xferRamAddr) && $stable(xferChan);
	endproperty
	a_info: assert property (p_info) else $error("item info moved");
	// Main scenarios reached.
	c_wide: cover property (xferRead && xferWide);
	c_irq0: cover property (completionIrq0);
	c_irq1: cover property (completionIrq1);
endmodule // dmactl_chk

// >>> testbench/dmactl_top_tb.sv
// Self-checking bench for the DMA control block.
`timescale 1ns/10ps
`include "dmactl_regs.vh"
module dmactl_top_tb;
	// Stimulus.
	reg         clk = 1'b0;
	reg         rst = 1'b1;
	reg         hsel = 1'b0;
	reg  [31:0] haddr = 32'h0;
	reg  [1:0]  htrans = 2'h0;
	reg         hwrite = 1'b0;
	reg  [31:0] hwdata = 32'h0;
	reg  [3:0]  lineIdx = 4'h0;
	reg         fire = 1'b0;
	// Design outputs.
	wire [31:0] hrdata;
	wire [13:0] evt;
	wire [15:0] xferRamAddr;
	wire [7:0]  xferPeriphAddr;
	wire        hreadyout, hresp, xferRead, xferWrite, xferDir, xferWide;
	wire        xferChan, cpuHold, completionIrq0, completionIrq1;
	// Bookkeeping.
	integer     errors = 0;
	integer     totalChecks = 0;
	integer     i;
	reg  [31:0] scratch;
	reg         lastDir, lastWide;
	reg  [7:0]  lastPer;
	always #25 clk = ~clk;
	// The single slave answers for the whole bus.
	dmactl_top DUT (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .timer0Event(evt[0]), .timer1Event(evt[1]),
		.timer4Event(evt[2]), .timer5Event(evt[3]),
		.serial0TxEvent(evt[4]), .clockedSerial00Event(evt[5]),
		.serial0RxEvent(evt[6]), .serial1TxEvent(evt[7]),
		.clockedSerial10Event(evt[8]), .twowire10Event(evt[9]),
		.serial1RxEvent(evt[10]), .serial3TxEvent(evt[11]),
		.serial3RxEvent(evt[12]), .conversionDoneEvent(evt[13]),
		.xferRead(xferRead), .xferWrite(xferWrite), .xferDir(xferDir),
		.xferWide(xferWide), .xferChan(xferChan), .xferRamAddr(xferRamAddr),
		.xferPeriphAddr(xferPeriphAddr), .cpuHold(cpuHold),
		.completionIrq0(completionIrq0), .completionIrq1(completionIrq1));
	dmactl_evt_model SRC (.clk(clk), .rst(rst), .lineIdx(lineIdx),
		.fire(fire), .evt(evt));
	// Remember the mode of the last item moved.
	always @(negedge clk) begin
		if (xferRead === 1'b1) begin
			lastDir = xferDir;
			lastWide = xferWide;
			lastPer = xferPeriphAddr;
		end
	end
	// Compare and count.
	task chk(input [31:0] seen, input [31:0] exp, input string what);
		begin
			totalChecks = totalChecks + 1;
			if (seen !== exp) begin
				errors = errors + 1;
				$display("wrong value %s: expected %h, seen %h", what, exp, seen);
			end
		end
	endtask
	// One single AHB-Lite transfer; read data is taken at the closing edge.
	task bus(input [19:0] idx, input w, input [31:0] d, output [31:0] r);
		begin
			@(posedge clk);
			hsel <= 1'b1;
			haddr <= {10'h000, idx, 2'h0};
			htrans <= 2'h2;
			hwrite <= w;
			@(posedge clk);
			while (hreadyout !== 1'b1) @(posedge clk);
			hsel <= 1'b0;
			htrans <= 2'h0;
			hwdata <= d;
			@(posedge clk);
			while (hreadyout !== 1'b1) @(posedge clk);
			r = hrdata;
		end
	endtask
	task wr(input [19:0] idx, input [31:0] d);
		bus(idx, 1'b1, d, scratch);
	endtask
	task rd(input [19:0] idx, input [31:0] exp);
		begin
			bus(idx, 1'b0, 32'h0, scratch);
			chk(scratch, exp, "register");
		end
	endtask
	// Enable first, set pointers and mode while idle, then start.
	task arm(input ch, input [7:0] mode, input [9:0] cnt);
		begin
			wr(ch ? `DMACTL_IDX_OPER1 : `DMACTL_IDX_OPER0, 32'h80);
			wr(ch ? `DMACTL_IDX_PERIPH1 : `DMACTL_IDX_PERIPH0, 32'h11);
			wr(ch ? `DMACTL_IDX_RAMPTR1 : `DMACTL_IDX_RAMPTR0, 32'h100);
			wr(ch ? `DMACTL_IDX_COUNT1 : `DMACTL_IDX_COUNT0, {22'h0, cnt});
			wr(ch ? `DMACTL_IDX_MODE1 : `DMACTL_IDX_MODE0, {24'h0, mode});
			wr(ch ? `DMACTL_IDX_OPER1 : `DMACTL_IDX_OPER0, 32'h81);
		end
	endtask
	// Pulse one source line.
	task ev(input [3:0] n);
		begin
			@(posedge clk);
			lineIdx <= n;
			fire <= 1'b1;
			@(posedge clk);
			fire <= 1'b0;
		end
	endtask
	// Wait a bounded time for the first completion pulse, if any.
	task wirq(input [1:0] exp);
		integer n;
		reg [1:0] s;
		begin
			s = 2'h0;
			for (n = 0; n < 40 && s == 2'h0; n = n + 1) begin
				@(negedge clk);
				s = {completionIrq1, completionIrq0};
			end
			chk({30'h0, s}, {30'h0, exp}, "completion");
		end
	endtask
	task stopTest;
		begin
			if (errors == 0 && totalChecks > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	// Hang guard, far beyond the expected run.
	initial begin
		#400000;
		errors = errors + 1;
		stopTest;
	end
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rd(`DMACTL_IDX_MODE0, 32'h0);
		rd(`DMACTL_IDX_MODE1, 32'h0);
		rd(`DMACTL_IDX_OPER0, 32'h0);
		rd(`DMACTL_IDX_OPER1, 32'h0);
		rd(20'hFFFBE, 32'h0);
		// Every source line under its code, one item each.
		for (i = 0; i < 14; i = i + 1) begin
			arm(0, i < 4 ? i + 2 : i < 6 ? 6 : i == 6 ? 7 : i < 10 ? 8 : i - 1, 1);
			ev(i);
			wirq(2'h1);
		end
		rd(`DMACTL_IDX_OPER0, 32'h80);
		chk(lastDir, 1'b0, "direction");
		chk(lastPer, 8'h11, "peripheral address");
		// Source zero: only the software trigger starts.
		arm(0, 8'h00, 2);
		ev(0);
		wirq(2'h0);
		rd(`DMACTL_IDX_COUNT0, 32'h2);
		wr(`DMACTL_IDX_MODE0, 32'h80);
		wirq(2'h0);
		rd(`DMACTL_IDX_COUNT0, 32'h1);
		rd(`DMACTL_IDX_MODE0, 32'h0);
		rd(`DMACTL_IDX_RAMPTR0, 32'h101);
		rd(`DMACTL_IDX_PERIPH0, 32'h11);
		// Held halfword request, released, then aborted.
		arm(0, 8'h72, 2);
		ev(0);
		wirq(2'h0);
		rd(`DMACTL_IDX_COUNT0, 32'h2);
		wr(`DMACTL_IDX_MODE0, 32'h62);
		wirq(2'h0);
		rd(`DMACTL_IDX_COUNT0, 32'h1);
		rd(`DMACTL_IDX_RAMPTR0, 32'h102);
		chk(lastDir, 1'b1, "direction");
		chk(lastWide, 1'b1, "size");
		chk(lastPer, 8'h10, "peripheral address");
		wr(`DMACTL_IDX_OPER0, 32'h80);
		ev(0);
		wirq(2'h0);
		rd(`DMACTL_IDX_COUNT0, 32'h1);
		rd(`DMACTL_IDX_RAMPTR0, 32'h102);
		wr(`DMACTL_IDX_OPER0, 32'h00);
		// Busy without enable: neither source nor trigger may start it.
		wr(`DMACTL_IDX_OPER0, 32'h01);
		rd(`DMACTL_IDX_OPER0, 32'h01);
		ev(0);
		wr(`DMACTL_IDX_MODE0, 32'hE2);
		wirq(2'h0);
		rd(`DMACTL_IDX_COUNT0, 32'h1);
		// Enable write refused while busy, then shared source priority.
		arm(1, 8'h02, 1);
		wr(`DMACTL_IDX_OPER1, 32'h01);
		rd(`DMACTL_IDX_OPER1, 32'h81);
		arm(0, 8'h02, 1);
		ev(0);
		wirq(2'h1);
		wirq(2'h2);
		// Both busy channels held together, then released one by one.
		arm(1, 8'h12, 1);
		arm(0, 8'h12, 1);
		ev(0);
		wirq(2'h0);
		wr(`DMACTL_IDX_MODE1, 32'h02);
		wirq(2'h2);
		wr(`DMACTL_IDX_MODE0, 32'h02);
		wirq(2'h1);
		// Trigger bit with a hardware source selected; fields unchanged.
		arm(1, 8'h05, 1);
		wr(`DMACTL_IDX_MODE1, 32'h85);
		wirq(2'h2);
		stopTest;
	end
endmodule // dmactl_top_tb
bind dmactl_top dmactl_chk u_chk (.clk(clk), .rst(rst),
	.hreadyout(hreadyout), .hresp(hresp), .xferRead(xferRead),
	.xferWrite(xferWrite), .xferWide(xferWide), .xferChan(xferChan),
	.xferRamAddr(xferRamAddr), .xferPeriphAddr(xferPeriphAddr),
	.cpuHold(cpuHold), .completionIrq0(completionIrq0),
	.completionIrq1(completionIrq1));
